// [rtl/fault_pkg.sv]
package fault_pkg;
    // Error status word layout
    localparam int ERR_W = 8;
    localparam int ERR_OC_BIT = 0;
    localparam int ERR_DC_BIT = 1;
    localparam int ERR_UV_BIT = 2;
    localparam int ERR_TW_BIT = 4;
    localparam int ERR_TE_BIT = 5;
    localparam logic [7:0] ERR_RESET = 8'h00;
    // Host register locations served by the register file outside this block
    localparam logic [7:0] ERR_REG_ADDR = 8'h7C;
    localparam logic [7:0] CLEAR_REG_ADDR = 8'h2D;
    localparam int CLEAR_BIT_POS = 2;
    localparam logic [7:0] DC_EN_REG_ADDR = 8'h26;
    localparam int DC_EN_BIT_POS = 2;
    localparam logic DC_EN_RESET = 1'b1;
    // Comparator trip points (degrees C and mV), set by the analog sensors
    localparam int TE_SET_C = 150;
    localparam int TE_CLR_C = 135;
    localparam int TW_SET_C = 125;
    localparam int TW_CLR_C = 105;
    localparam int UV_LOGIC_RELEASE_MV = 4200;
    localparam int UV_LOGIC_ENGAGE_MV = 4000;
    localparam int UV_STAGE_RELEASE_MV = 4300;
    localparam int UV_STAGE_ENGAGE_MV = 4100;
    // DC band edges in thousandths of the stage supply
    localparam int DC_HIGH_PERMILLE = 630;
    localparam int DC_LOW_PERMILLE = 370;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int DC_HOLD_MS = 700;
    localparam int DC_HOLD_CYCLES = DC_HOLD_MS * 1000 * CLK_MHZ;
    localparam int OC_RETRY_NS = 1000;
    localparam int OC_RETRY_CYCLES = (OC_RETRY_NS * CLK_MHZ + 999) / 1000;
    localparam int RETRY_W = 16;
    // Over-current recovery states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_OC_OFF = 2'b01,
        ST_RESTART = 2'b10
    } oc_state_e;
endpackage

// [rtl/sync_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(parameter int W = 1)
(
    sync_if.sync bus,
    input wire logic clk,
    input wire logic rst,
    input wire logic ce
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } sync_s;

    sync_s r;
    sync_s n;

    if (W < 1) begin : g_chk
        $error("pin_sync needs at least one bit");
    end

    // Three stages; a level is taken once stages two and three agree
    always_comb
    begin
        n = r;
        n.s1 = bus.raw;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.clean = (r.s2 & r.s3) | (r.clean & (r.s2 | r.s3));
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= '0;
        else if (ce)
            r <= n;
    end

    assign bus.clean = r.clean;

    // A clean bit moves only toward agreeing later stages
    a_sync_agree_only: assert property (@(posedge clk) disable iff (rst)
        (ce && (r.s2 == r.s3)) |=> (r.clean == $past(r.s2)))
        else $error("synchronised level does not follow agreeing stages");
endmodule
`default_nettype wire

// [rtl/amp_fault_guard.sv]
// How it works
// (R1) Over-current comparators count only for switches on while the stage switches.
// (R2) Over-current latches, shuts the stage down and pulls the fault pin low.
// (R3) After an over-current pause the stage restarts with a default-config pulse.
// (R4) Thermal warning sets error bit 4, readable by the host.
// (R5) Thermal error sets error bit 5 and halts all switching.
// (R6) Thermal error sets at its high trip, releases at the lower one.
// (R7) Thermal warning sets at its high trip, clears at the lower one.
// (R8) Warning or error thermal condition pulls the fault pin low.
// (R9) Logic and analog supply lockout engages low, releases at higher level.
// (R10) Stage supply lockout engages low, releases at its higher level.
// (R11) An output outside the band for the hold time is a DC fault.
// (R12) A DC fault shuts the power stage down.
// (R13) A DC fault shows on the fault pin and in the error word.
// (R14) Toggling the clear bit or cycling enable clears the errors and restarts.
// (R15) DC protection is on after reset; clearing its enable turns it off.
// (R16) The DC timer restarts whenever the output returns inside the band.
// (R17) Fault pin is the OR of every active condition and the latched DC fault; the latched over-current bit is not on it.
`timescale 1ns/1ps
`default_nettype none
module amp_fault_guard
    import fault_pkg::*;
#(
    parameter int N_SW = 8,
    parameter int N_OUT = 4,
    parameter int DC_LIMIT = DC_HOLD_CYCLES
)
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [N_SW-1:0] OC_DETECT,
    input wire logic [N_SW-1:0] SW_ON,
    input wire logic TW_ABOVE_SET,
    input wire logic TW_ABOVE_CLR,
    input wire logic TE_ABOVE_SET,
    input wire logic TE_ABOVE_CLR,
    input wire logic DIG_BELOW_ENGAGE,
    input wire logic DIG_ABOVE_RELEASE,
    input wire logic ANA_BELOW_ENGAGE,
    input wire logic ANA_ABOVE_RELEASE,
    input wire logic PWR_BELOW_ENGAGE,
    input wire logic PWR_ABOVE_RELEASE,
    input wire logic [N_OUT-1:0] OUT_ABOVE_BAND,
    input wire logic [N_OUT-1:0] OUT_BELOW_BAND,
    input wire logic ENABLE_N,
    input wire logic CLEAR_BIT,
    input wire logic DC_SHUTDOWN_ENABLE,
    output logic FAULT_N,
    output logic STAGE_SHUTDOWN,
    output logic SWITCH_HALT,
    output logic RESTART_DEFAULT,
    output logic [ERR_W-1:0] ERR_STATUS
);
    localparam int SW = N_SW + 2 * N_OUT + 11;
    localparam int CW = $clog2(DC_LIMIT + 1);
    localparam logic [CW-1:0] DC_END = CW'(DC_LIMIT);
    localparam logic [RETRY_W-1:0] RETRY_END = RETRY_W'(OC_RETRY_CYCLES - 1);

    if (N_SW < 1 || N_OUT < 1 || DC_LIMIT < 1 || N_SW > 64)
    begin : g_chk
        $error("amp_fault_guard parameters out of range");
    end

    typedef struct packed {
        oc_state_e st;
        logic [RETRY_W-1:0] retry;
        logic [N_OUT-1:0][CW-1:0] dc_cnt;
        logic dc_fault;
        logic tw;
        logic te;
        logic [2:0] uv;
        logic oc_seen;
        logic clr_q;
        logic fault_n;
        logic shutdown;
        logic halt;
        logic restart;
        logic [ERR_W-1:0] err;
    } guard_s;

    guard_s r;
    guard_s n;

    sync_if #(.W(SW)) pins();

    // Every analog comparator and the enable pin enter through the synchroniser
    assign pins.raw = {ENABLE_N, OUT_BELOW_BAND, OUT_ABOVE_BAND,
                       PWR_ABOVE_RELEASE, PWR_BELOW_ENGAGE,
                       ANA_ABOVE_RELEASE, ANA_BELOW_ENGAGE,
                       DIG_ABOVE_RELEASE, DIG_BELOW_ENGAGE,
                       TE_ABOVE_CLR, TE_ABOVE_SET,
                       TW_ABOVE_CLR, TW_ABOVE_SET, OC_DETECT};

    pin_sync #(.W(SW)) u_sync (
        .bus(pins.sync),
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .ce(CE)
    );

    logic [N_SW-1:0] oc_s;
    logic tw_set, tw_hold, te_set, te_hold;
    logic [2:0] uv_engage, uv_release;
    logic [N_OUT-1:0] dc_hi, dc_lo, dc_out, dc_hit;
    logic en_n;
    logic oc_hit, clr_evt, clear, uv_any;

    assign oc_s = pins.clean[N_SW-1:0];
    assign tw_set = pins.clean[N_SW];
    assign tw_hold = pins.clean[N_SW+1];
    assign te_set = pins.clean[N_SW+2];
    assign te_hold = pins.clean[N_SW+3];
    assign uv_engage = {pins.clean[N_SW+8], pins.clean[N_SW+6],
                        pins.clean[N_SW+4]};
    assign uv_release = {pins.clean[N_SW+9], pins.clean[N_SW+7],
                         pins.clean[N_SW+5]};
    assign dc_hi = pins.clean[N_SW+10 +: N_OUT];
    assign dc_lo = pins.clean[N_SW+10+N_OUT +: N_OUT];
    assign en_n = pins.clean[SW-1];
    assign dc_out = dc_hi | dc_lo;

    // Event terms shared by the next-state logic and the checks
    always_comb
    begin
        oc_hit = (r.st == ST_RUN) && !r.shutdown && !r.halt
                 && |(oc_s & SW_ON); // see (R1)
        clr_evt = CLEAR_BIT != r.clr_q; // see (R14)
        clear = clr_evt | en_n; // see (R14)
        uv_any = |r.uv;
        for (int i = 0; i < N_OUT; i++)
            dc_hit[i] = r.dc_cnt[i] == DC_END; // see (R11)
    end

    // Next state of the whole guard
    always_comb
    begin
        n = r;
        n.restart = 1'b0;
        n.clr_q = CLEAR_BIT;
        // Hysteresis: thermal sets high, holds until the low trip drops; lockout engages low, holds until release rises
        n.tw = tw_set | (r.tw & tw_hold); // see (R7)
        n.te = te_set | (r.te & te_hold); // see (R6)
        for (int k = 0; k < 3; k++)
            n.uv[k] = uv_engage[k] | (r.uv[k] & !uv_release[k]); // see (R9) (R10)
        // Persistence timers, zeroed on any return inside the band
        for (int i = 0; i < N_OUT; i++)
        begin
            if (!DC_SHUTDOWN_ENABLE || !dc_out[i] || en_n)
                n.dc_cnt[i] = '0; // see (R15) (R16)
            else if (!dc_hit[i])
                n.dc_cnt[i] = r.dc_cnt[i] + 1'b1; // see (R11)
        end
        // Latched faults; a new event wins over a clear
        n.dc_fault = |dc_hit | (r.dc_fault & !clear); // see (R12) (R14)
        n.oc_seen = oc_hit | (r.oc_seen & !clear);
        // Over-current shutdown and automatic retry
        case (r.st)
            ST_RUN:
            begin
                n.retry = '0;
                if (oc_hit)
                    n.st = ST_OC_OFF; // see (R2)
            end
            ST_OC_OFF:
            begin
                n.retry = r.retry + 1'b1;
                if (r.retry == RETRY_END)
                    n.st = ST_RESTART;
            end
            ST_RESTART:
            begin
                n.restart = 1'b1; // see (R3)
                n.st = ST_RUN;
            end
            default:
                n.st = ST_RUN;
        endcase
        // Output flops
        n.shutdown = (n.st != ST_RUN) | n.dc_fault | (|n.uv) | en_n; // see (R2) (R12)
        n.halt = n.te; // see (R5)
        n.fault_n = !((n.st != ST_RUN) | n.dc_fault | n.tw | n.te
                      | (|n.uv)); // see (R8) (R13) (R17)
        // Error word, registered on the same edge as its causes
        n.err = ERR_RESET;
        n.err[ERR_OC_BIT] = n.oc_seen;
        n.err[ERR_DC_BIT] = n.dc_fault; // see (R13)
        n.err[ERR_UV_BIT] = |n.uv;
        n.err[ERR_TW_BIT] = n.tw; // see (R4)
        n.err[ERR_TE_BIT] = n.te; // see (R5)
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            r <= '0;
            r.st <= ST_RUN;
            r.fault_n <= 1'b1;
            r.err <= ERR_RESET;
        end
        else if (CE)
            r <= n;
    end

    // Every output is a register bit of the state
    assign ERR_STATUS = r.err;
    assign FAULT_N = r.fault_n;
    assign STAGE_SHUTDOWN = r.shutdown;
    assign SWITCH_HALT = r.halt;
    assign RESTART_DEFAULT = r.restart;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    a_oc_shuts_stage: assert property ( // see (R2)
        (CE && oc_hit) |=> STAGE_SHUTDOWN && !FAULT_N && r.st == ST_OC_OFF)
        else $error("over-current did not shut the stage down");
    a_oc_auto_restart: assert property ( // see (R3)
        (CE && r.st == ST_OC_OFF && r.retry == RETRY_END) ##1 CE
        |=> RESTART_DEFAULT && r.st == ST_RUN)
        else $error("no restart after over-current pause");
    a_oc_needs_switch: assert property ( // see (R1)
        (CE && r.st == ST_RUN && !(|(oc_s & SW_ON))) |=> r.st == ST_RUN)
        else $error("over-current taken on a switch that is off");
    a_te_halts_switching: assert property ( // see (R5)
        (CE && te_set) |=> SWITCH_HALT && ERR_STATUS[ERR_TE_BIT])
        else $error("thermal error did not halt switching");
    a_tw_hysteresis_hold: assert property ( // see (R7)
        (CE && r.tw && tw_hold) |=> r.tw)
        else $error("warning released above its clear trip");
    a_thermal_fault_pin: assert property ( // see (R8)
        (r.tw || r.te) |-> !FAULT_N)
        else $error("thermal condition not on fault pin");
    a_uv_lockout: assert property ( // see (R9) (R10)
        uv_any |-> STAGE_SHUTDOWN && !FAULT_N)
        else $error("supply lockout did not stop the stage");
    a_dc_timer_restart: assert property ( // see (R16)
        (CE && !dc_out[0]) |=> r.dc_cnt[0] == '0)
        else $error("DC timer kept running inside the band");
    a_dc_fault_report: assert property ( // see (R12)
        (CE && dc_hit[0])
        |=> ERR_STATUS[ERR_DC_BIT] && STAGE_SHUTDOWN && !FAULT_N)
        else $error("DC fault not latched or stage left on");
    a_dc_clear_works: assert property ( // see (R14)
        (CE && r.dc_fault && clear && !(|dc_hit)) |=> !r.dc_fault)
        else $error("clear did not drop the DC fault");
    a_dc_disable_gate: assert property ( // see (R15)
        (CE && !DC_SHUTDOWN_ENABLE) |=> !(|dc_hit))
        else $error("DC timer ran with protection disabled");
endmodule
`default_nettype wire

// [verif/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host controller: flips the clear bit on request, owns the DC enable
module host_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clr_req,
    input wire logic dc_en_req,
    output logic clear_bit,
    output logic dc_en
);
    // Both host bits change only on the shared clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clear_bit <= 1'h0;
            dc_en <= 1'h1;
        end
        else
        begin
            if (clr_req)
                clear_bit <= ~clear_bit;
            dc_en <= dc_en_req;
        end
    end
endmodule
`default_nettype wire

// [verif/amp_fault_guard_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module amp_fault_guard_tb;
    import fault_pkg::*;
    localparam int LIM = 20;
    logic clk, rst, ce, en_n, clr_req, dc_req;
    logic [7:0] oc, sw;
    logic [1:0] tset, tclr;
    logic [2:0] ube, uar;
    logic [3:0] oab, obb;
    logic clear_bit, dc_en, fault_n, shut, halt, rdef;
    logic [7:0] err;
    logic [10:0] notes[$];
    logic [31:0] seed;
    int n_mismatch, cmp_count, k, b, w;
    event chk_ev;
    amp_fault_guard #(.N_SW(8), .N_OUT(4), .DC_LIMIT(LIM)) DUT (
        .SYS_CLK(clk), .SYS_RST(rst), .CE(ce),
        .OC_DETECT(oc), .SW_ON(sw),
        .TW_ABOVE_SET(tset[0]), .TW_ABOVE_CLR(tclr[0]),
        .TE_ABOVE_SET(tset[1]), .TE_ABOVE_CLR(tclr[1]),
        .DIG_BELOW_ENGAGE(ube[0]), .DIG_ABOVE_RELEASE(uar[0]),
        .ANA_BELOW_ENGAGE(ube[1]), .ANA_ABOVE_RELEASE(uar[1]),
        .PWR_BELOW_ENGAGE(ube[2]), .PWR_ABOVE_RELEASE(uar[2]),
        .OUT_ABOVE_BAND(oab), .OUT_BELOW_BAND(obb),
        .ENABLE_N(en_n), .CLEAR_BIT(clear_bit),
        .DC_SHUTDOWN_ENABLE(dc_en), .FAULT_N(fault_n),
        .STAGE_SHUTDOWN(shut), .SWITCH_HALT(halt),
        .RESTART_DEFAULT(rdef), .ERR_STATUS(err));
    host_model host (.clk(clk), .rst(rst), .clr_req(clr_req),
        .dc_en_req(dc_req), .clear_bit(clear_bit), .dc_en(dc_en));
    // 200 MHz system clock
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Move to just after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Note the expected outputs and wake the monitor
    task automatic expect_out(input logic f, s, h, input logic [7:0] e);
        notes.push_back({f, s, h, e});
        ->chk_ev;
        step(1);
    endtask
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Drive the chosen output out of band or back inside it
    task automatic dc_set(input logic v);
        if (b == 1)
            oab[k] = v;
        else
            obb[k] = v;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Monitor compares live outputs with the oldest note
    always @(chk_ev)
        if (notes.size() > 0)
            check({fault_n, shut, halt, err}, notes.pop_front());
    // Watchdog
    initial
    begin
        #50000;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        seed = 32'h81F9D532;
        rst = 1'h1;
        ce = 1'h1;
        {en_n, clr_req, oc, sw, tset, tclr, ube, oab, obb} = '0;
        dc_req = 1'h1;
        uar = 3'h7;
        step(6);
        rst = 1'h0;
        step(4);
        expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        // Over-current on a switch that is off, then on
        k = int'(rnd() % 8);
        oc[k] = 1'h1;
        sw = ~(8'h01 << k);
        step(8);
        expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        sw = 8'h01 << k;
        step(8);
        expect_out(1'h0, 1'h1, 1'h0, 8'h01 << ERR_OC_BIT);
        oc = '0;
        for (w = 0; w < 400 && rdef !== 1'h1; w++)
            step(1);
        check({10'h000, rdef}, 11'h001);
        // Pulse one edge after the pause, which starts one edge after the switch turns on; 9 edges were spent before the loop
        check(11'(w), 11'(OC_RETRY_CYCLES - 7));
        step(1);
        check({10'h000, rdef}, 11'h000);
        step(1);
        expect_out(1'h1, 1'h0, 1'h0, 8'h01 << ERR_OC_BIT);
        clr_req = 1'h1;
        step(1);
        clr_req = 1'h0;
        step(4);
        expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        // Warning then error, each with its hysteresis
        for (int i = 0; i < 2; i++)
        begin
            b = i ? ERR_TE_BIT : ERR_TW_BIT;
            tclr[i] = 1'h1;
            step(8);
            expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
            tset[i] = 1'h1;
            step(8);
            expect_out(1'h0, 1'h0, i[0], 8'h01 << b);
            tset[i] = 1'h0;
            step(8);
            expect_out(1'h0, 1'h0, i[0], 8'h01 << b);
            tclr[i] = 1'h0;
            step(8);
            expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        end
        // Lockout per supply, held between the two levels
        for (int i = 0; i < 3; i++)
        begin
            ube[i] = 1'h1;
            uar[i] = 1'h0;
            step(8);
            expect_out(1'h0, 1'h1, 1'h0, 8'h01 << ERR_UV_BIT);
            ube[i] = 1'h0;
            step(8);
            expect_out(1'h0, 1'h1, 1'h0, 8'h01 << ERR_UV_BIT);
            uar[i] = 1'h1;
            step(8);
            expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        end
        // Broken excursions must not add up
        k = int'(rnd() % 4);
        b = int'(rnd() % 2);
        repeat (2)
        begin
            dc_set(1'h1);
            step(12);
            dc_set(1'h0);
            step(8);
        end
        expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        dc_set(1'h1);
        // Four edges to pass the synchroniser, then LIM counted edges
        step(LIM + 4);
        expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        expect_out(1'h0, 1'h1, 1'h0, 8'h01 << ERR_DC_BIT);
        dc_set(1'h0);
        step(8);
        expect_out(1'h0, 1'h1, 1'h0, 8'h01 << ERR_DC_BIT);
        // Clock enable low freezes all state, the enable pin included
        ce = 1'h0;
        en_n = 1'h1;
        step(8);
        expect_out(1'h0, 1'h1, 1'h0, 8'h01 << ERR_DC_BIT);
        ce = 1'h1;
        step(8);
        en_n = 1'h0;
        step(8);
        expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        // Protection switched off by the host
        dc_req = 1'h0;
        step(2);
        dc_set(1'h1);
        step(LIM + 10);
        expect_out(1'h1, 1'h0, 1'h0, ERR_RESET);
        dc_set(1'h0);
        dc_req = 1'h1;
        step(4);
        stop_test();
    end
endmodule
`default_nettype wire
